// *** design/rdoc_pkg.sv ***
// Constants for the remote decoder output and control block.
// Assumes a 100 MHz sys_clk and a synchronous active-high reset.
// Operation
// R1: Record for every well-coded packet, learnt or not
// R2: Record needs only Manchester check, no decryption
// R3: 9600 baud, 8 data, 1 stop, no parity
// R4: Ten characters: serial, button, CR, LF
// R5: Uppercase hex digits, most significant first
// R6: Button char bits D0-D3; lowercase if low battery
// R7: Records at least 150 ms apart
// R8: Decoded outputs low for active switches
// R9: Decoded outputs follow learnt transmitters only
// R10: Select high toggles, low is momentary
// R11: Low-battery flag latched until good battery
// R12: Select low: sample clock line as strap
// R13: Pull-down means AM sync-low, pull-up FM
// R14: Brief learn pin press enters learn
// R15: Hold over 8 s starts erase
// R16: Learn LED: on, off, flash, stored
// R17: Seven internal, 48 with external EEPROM
// R18: Erase LED: on while held, flash, dark
// R19: One pin is switch and LED drive
// R20: Host takes records only while output asserted
// R21: Sleep input low sleeps, high runs
// R22: Sleep holds decoded outputs and flag high
// R23: Learn pin wakes from sleep, then back
// R24: Momentary outputs held at least 350 ms
// R25: Short press is learn, never erase
// R26: New record only after LF stop bit
package rdoc_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BAUD = 9600;
  localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
  localparam int unsigned CHAR_BITS = 10;
  localparam int unsigned REC_CHARS = 10;
  localparam int unsigned SN_DIGITS = 7;
  localparam int unsigned REC_GAP_MS = 150;
  localparam int unsigned REC_GAP_CYC = REC_GAP_MS * (CLK_HZ / 1000);
  localparam int unsigned MOM_MS = 350;
  localparam int unsigned MOM_CYC = MOM_MS * (CLK_HZ / 1000);
  localparam int unsigned ERASE_S = 8;
  localparam int unsigned ERASE_CYC = ERASE_S * CLK_HZ;
  localparam int unsigned FLASH_MS = 100;
  localparam int unsigned FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);
  localparam int unsigned INT_SLOTS = 7;
  localparam int unsigned EXT_SLOTS = 48;
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_LF = 8'h0A;
  localparam logic [7:0] BTN_UPPER = 8'h40;
  localparam logic [7:0] BTN_LOWER = 8'h60;
  localparam logic [3:0] OUT_RST = 4'hF;
endpackage : rdoc_pkg

// *** design/rdoc_fifo2.sv ***
// Two-entry valid/ready buffer for record characters.
// Assumes one clock domain; both sides handshake on valid and ready.
module rdoc_fifo2 #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_ff [2];
  logic rd_ptr_ff;
  logic wr_ptr_ff;
  logic [1:0] count_ff;
  logic do_wr;
  logic do_rd;

  assign in_ready = (count_ff != 2'h2);
  assign out_valid = (count_ff != 2'h0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always_ff @(posedge sys_clk)
  begin
    if (do_wr)
    begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rd_ptr_ff <= 1'b0;
      wr_ptr_ff <= 1'b0;
      count_ff <= 2'h0;
    end
    else
    begin
      if (do_wr)
        wr_ptr_ff <= ~wr_ptr_ff;
      if (do_rd)
        rd_ptr_ff <= ~rd_ptr_ff;
      count_ff <= count_ff + {1'b0, do_wr} - {1'b0, do_rd};
    end
  end
endmodule : rdoc_fifo2

// *** design/rdoc_uart_tx.sv ***
// Asynchronous 8N1 character transmitter, idle high.
// Assumes characters arrive on a valid/ready handshake.
module rdoc_uart_tx #(
  parameter int unsigned BIT_CYCLES = rdoc_pkg::BIT_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Character in
  input wire logic chr_valid,
  output logic chr_ready,
  input wire logic [7:0] chr_data,
  // Line
  output logic tx_line,
  output logic tx_busy
);
  logic [8:0] shift_ff;
  logic [3:0] bits_left_ff;
  logic [15:0] baud_ff;
  logic line_ff;

  assign chr_ready = (bits_left_ff == 4'h0);
  assign tx_line = line_ff;
  assign tx_busy = (bits_left_ff != 4'h0);

  // Start bit, 8 data LSB first, one stop bit, no parity [R3]
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      shift_ff <= 9'h1FF;
      bits_left_ff <= 4'h0;
      baud_ff <= 16'h0000;
      line_ff <= 1'b1;
    end
    else if (bits_left_ff == 4'h0)
    begin
      if (chr_valid)
      begin
        line_ff <= 1'b0;
        shift_ff <= {1'b1, chr_data};
        bits_left_ff <= 4'(rdoc_pkg::CHAR_BITS);
        baud_ff <= 16'(BIT_CYCLES - 1);
      end
    end
    else if (baud_ff != 16'h0000)
    begin
      baud_ff <= baud_ff - 16'h0001;
    end
    else
    begin
      // Last count ends the stop bit, so busy covers it fully [R26]
      bits_left_ff <= bits_left_ff - 4'h1;
      baud_ff <= 16'(BIT_CYCLES - 1);
      line_ff <= (bits_left_ff == 4'h1) ? 1'b1 : shift_ff[0];
      shift_ff <= {1'b1, shift_ff[8:1]};
    end
  end
endmodule : rdoc_uart_tx

// *** design/rdoc_top.sv ***
// Output and control logic of the rolling-code remote decoder.
// Assumes the demodulator gives one-cycle packet strobes with fields.
module rdoc_top #(
  parameter int unsigned REC_GAP_CYCLES = rdoc_pkg::REC_GAP_CYC,
  parameter int unsigned MOM_CYCLES = rdoc_pkg::MOM_CYC,
  parameter int unsigned ERASE_CYCLES = rdoc_pkg::ERASE_CYC,
  parameter int unsigned FLASH_CYCLES = rdoc_pkg::FLASH_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Packet from the demodulator
  input wire logic pkt_valid,
  input wire logic pkt_coding_ok,
  input wire logic pkt_learnt,
  input wire logic [27:0] pkt_serial,
  input wire logic encoder_switch_0,
  input wire logic encoder_switch_1,
  input wire logic encoder_switch_2,
  input wire logic encoder_switch_3,
  input wire logic pkt_low_batt,
  input wire logic rx_active,
  // Options and sleep pins
  input wire logic output_action_select,
  input wire logic sleep_run_n,
  // Decoded outputs and flag, active low
  output logic decoded_output_1,
  output logic decoded_output_2,
  output logic decoded_output_3,
  output logic decoded_output_4,
  output logic low_battery_flag,
  // Serial record out
  output logic ascii_serial_out,
  // Shared learn switch and LED pin
  input wire logic learn_erase_pin_in,
  output logic learn_erase_pin_out,
  output logic learn_erase_pin_oe,
  // EEPROM lines
  input wire logic eeprom_present,
  output logic eeprom_select,
  input wire logic eeprom_serial_clock_in,
  output logic eeprom_serial_clock_out,
  output logic eeprom_serial_clock_oe,
  // Memory engine handshake
  output logic learn_store_req,
  output logic erase_req,
  input wire logic erase_done,
  output logic sync_high_fm,
  output logic [5:0] slot_limit,
  output logic sleeping
);
  typedef enum logic [5:0] {
    LS_IDLE = 6'b000001,
    LS_PRESS = 6'b000010,
    LS_WAIT1 = 6'b000100,
    LS_WAIT2 = 6'b001000,
    LS_FLASH = 6'b010000,
    LS_ERASE = 6'b100000
  } rdoc_lrn_t;

  rdoc_lrn_t lrn_state_ff;
  rdoc_lrn_t nxt_lrn_state;

  logic [1:0] lrn_sync_ff;
  logic [1:0] clk_sync_ff;
  logic [1:0] sleep_sync_ff;
  logic pressed;
  logic asleep;
  logic [31:0] hold_cnt_ff;
  logic [31:0] flash_cnt_ff;
  logic [2:0] flash_n_ff;
  logic led_ff;
  logic store_ff;
  logic erase_ff;
  logic [3:0] out_ff;
  logic [3:0] raw_ff;
  logic lb_ff;
  logic fm_ff;
  logic sel_ff;
  logic [31:0] mom_cnt_ff [4];
  logic [31:0] gap_cnt_ff;
  logic [3:0] chr_idx_ff;
  logic [27:0] sn_ff;
  logic [7:0] btn_ff;
  logic rec_busy_ff;
  logic [7:0] chr;
  logic [3:0] nib;
  logic f_valid;
  logic f_ready;
  logic u_valid;
  logic u_ready;
  logic [7:0] u_data;
  logic tx_busy;
  logic tx_line;
  logic [3:0] sw;
  logic good_pkt;
  logic [3:0] scan_ff;
  logic press_ff;
  logic oe_ff;

  assign sw = {encoder_switch_3, encoder_switch_2, encoder_switch_1,
    encoder_switch_0};
  assign pressed = press_ff;
  assign asleep = ~sleep_sync_ff[1];

  // Two-stage synchronisers for pins
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      lrn_sync_ff <= 2'h3;
      clk_sync_ff <= 2'h0;
      sleep_sync_ff <= 2'h3;
    end
    else
    begin
      lrn_sync_ff <= {lrn_sync_ff[0], learn_erase_pin_in};
      clk_sync_ff <= {clk_sync_ff[0], eeprom_serial_clock_in};
      sleep_sync_ff <= {sleep_sync_ff[0], sleep_run_n};
    end
  end

  // LED sink would mask the switch: drop it 4 cycles in 16, read after
  // the synchroniser has seen the undriven pin [R19]
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      scan_ff <= 4'h0;
      press_ff <= 1'b0;
      oe_ff <= 1'b0;
    end
    else
    begin
      scan_ff <= scan_ff + 4'h1;
      oe_ff <= led_ff && (scan_ff < 4'hC);
      if (scan_ff == 4'hF)
        press_ff <= ~lrn_sync_ff[1];
    end
  end

  // Awake runs normally; no new packets while asleep unless learning
  assign good_pkt = pkt_valid && pkt_coding_ok &&
    (!asleep || lrn_state_ff != LS_IDLE); // [R21] [R23]

  // Strap sensing while EEPROM unselected; pull-up picks FM [R12] [R13]
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      fm_ff <= 1'b0;
      sel_ff <= 1'b0;
    end
    else
    begin
      sel_ff <= 1'b0;
      if (!sel_ff)
        fm_ff <= clk_sync_ff[1]; // [R12]
    end
  end

  // Learn and erase sequencing on the shared pin
  always_comb
  begin
    nxt_lrn_state = lrn_state_ff;
    case (lrn_state_ff)
      LS_IDLE:
        if (pressed)
          nxt_lrn_state = LS_PRESS; // [R14] [R23]
      LS_PRESS:
        if (!pressed)
          nxt_lrn_state = LS_WAIT1; // [R25]
        else if (hold_cnt_ff >= ERASE_CYCLES)
          nxt_lrn_state = LS_ERASE; // [R15]
      LS_WAIT1:
        if (pkt_valid && pkt_coding_ok)
          nxt_lrn_state = LS_WAIT2; // [R16]
      LS_WAIT2:
        if (pkt_valid && pkt_coding_ok)
          nxt_lrn_state = LS_FLASH; // [R16]
      LS_FLASH:
        if (flash_n_ff == 3'h0 && flash_cnt_ff == 32'h0)
          nxt_lrn_state = LS_IDLE;
      LS_ERASE:
        if (erase_done && !pressed)
          nxt_lrn_state = LS_IDLE; // [R18]
      default:
        nxt_lrn_state = LS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      lrn_state_ff <= LS_IDLE;
    else
      lrn_state_ff <= nxt_lrn_state;
  end

  // Hold timer: over the limit only while still pressed [R15] [R25]
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || lrn_state_ff != LS_PRESS)
      hold_cnt_ff <= 32'h0;
    else if (hold_cnt_ff < ERASE_CYCLES)
      hold_cnt_ff <= hold_cnt_ff + 32'h1;
  end

  // Flash timer; during erase it runs until the memory engine is done and the pin is released
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      flash_cnt_ff <= 32'h0;
      flash_n_ff <= 3'h0;
    end
    else if (nxt_lrn_state == LS_FLASH && lrn_state_ff != LS_FLASH)
    begin
      flash_cnt_ff <= 32'(FLASH_CYCLES - 1);
      flash_n_ff <= 3'h5;
    end
    else if (flash_cnt_ff != 32'h0)
      flash_cnt_ff <= flash_cnt_ff - 32'h1;
    else if (lrn_state_ff == LS_ERASE ||
      (lrn_state_ff == LS_FLASH && flash_n_ff != 3'h0))
    begin
      flash_cnt_ff <= 32'(FLASH_CYCLES - 1);
      if (lrn_state_ff == LS_ERASE)
        flash_n_ff <= flash_n_ff ^ 3'h1;
      else
        flash_n_ff <= flash_n_ff - 3'h1;
    end
  end

  // LED drive on the same pin, lit even while the switch is held [R19]
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      led_ff <= 1'b0;
    else
      case (lrn_state_ff)
        LS_PRESS: led_ff <= 1'b1; // [R16] [R18]
        LS_WAIT1: led_ff <= 1'b1; // [R16]
        LS_FLASH: led_ff <= flash_n_ff[0]; // [R16]
        LS_ERASE: led_ff <= pressed | (erase_done ? 1'b0
          : flash_n_ff[0]); // [R18]
        default: led_ff <= 1'b0;
      endcase
  end

  // Store after second packet, erase request while in erase [R16] [R15]
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      store_ff <= 1'b0;
      erase_ff <= 1'b0;
    end
    else
    begin
      store_ff <= (lrn_state_ff == LS_WAIT2) && nxt_lrn_state == LS_FLASH;
      erase_ff <= (lrn_state_ff == LS_ERASE) && !erase_done;
    end
  end

  // Decoded outputs: learnt only, toggle or momentary [R8] [R9] [R10]
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_out
      always_ff @(posedge sys_clk)
      begin
        if (sys_rst)
        begin
          raw_ff[gi] <= 1'b0;
          mom_cnt_ff[gi] <= 32'h0;
        end
        else if (good_pkt && pkt_learnt && sw[gi])
        begin
          raw_ff[gi] <= output_action_select ? ~raw_ff[gi] : 1'b1; // [R10]
          mom_cnt_ff[gi] <= 32'(MOM_CYCLES - 1); // [R24]
        end
        else if (!output_action_select)
        begin
          if (mom_cnt_ff[gi] != 32'h0)
            mom_cnt_ff[gi] <= mom_cnt_ff[gi] - 32'h1;
          else if (!rx_active)
            raw_ff[gi] <= 1'b0; // [R24]
        end
      end
      always_ff @(posedge sys_clk)
      begin
        if (sys_rst)
          out_ff[gi] <= rdoc_pkg::OUT_RST[gi];
        else
          out_ff[gi] <= asleep ? 1'b1 : ~raw_ff[gi]; // [R8] [R22]
      end
    end
  endgenerate

  // Low-battery flag latch [R11]
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      lb_ff <= 1'b0;
    else if (good_pkt && pkt_learnt)
      lb_ff <= pkt_low_batt; // [R11]
  end

  // Record capture: any well-coded packet, no decryption [R1] [R2]
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rec_busy_ff <= 1'b0;
      chr_idx_ff <= 4'h0;
      sn_ff <= 28'h0;
      btn_ff <= 8'h00;
      gap_cnt_ff <= 32'h0;
    end
    else
    begin
      if (gap_cnt_ff != 32'h0)
        gap_cnt_ff <= gap_cnt_ff - 32'h1;
      if (!rec_busy_ff && good_pkt && gap_cnt_ff == 32'h0 && !tx_busy
        && !u_valid) // [R7] [R26]
      begin
        rec_busy_ff <= 1'b1;
        chr_idx_ff <= 4'h0;
        sn_ff <= pkt_serial; // [R1] [R2]
        btn_ff <= (pkt_low_batt ? rdoc_pkg::BTN_LOWER : rdoc_pkg::BTN_UPPER)
          | {4'h0, sw}; // [R6]
        gap_cnt_ff <= 32'(REC_GAP_CYCLES - 1); // [R7]
      end
      else if (rec_busy_ff && f_ready)
      begin
        chr_idx_ff <= chr_idx_ff + 4'h1;
        if (chr_idx_ff == 4'(rdoc_pkg::REC_CHARS - 1))
          rec_busy_ff <= 1'b0; // [R4]
      end
    end
  end

  // Character of the record: hex digits MSB first, button, CR, LF
  always_comb
  begin
    nib = sn_ff[27:24];
    case (chr_idx_ff)
      4'h0: nib = sn_ff[27:24];
      4'h1: nib = sn_ff[23:20];
      4'h2: nib = sn_ff[19:16];
      4'h3: nib = sn_ff[15:12];
      4'h4: nib = sn_ff[11:8];
      4'h5: nib = sn_ff[7:4];
      default: nib = sn_ff[3:0];
    endcase
    if (chr_idx_ff < 4'(rdoc_pkg::SN_DIGITS))
      chr = (nib < 4'hA) ? (8'h30 + {4'h0, nib})
        : (8'h37 + {4'h0, nib}); // [R5]
    else if (chr_idx_ff == 4'h7)
      chr = btn_ff; // [R4] [R6]
    else if (chr_idx_ff == 4'h8)
      chr = rdoc_pkg::CHAR_CR; // [R4]
    else
      chr = rdoc_pkg::CHAR_LF; // [R4]
  end

  assign f_valid = rec_busy_ff;

  rdoc_fifo2 #(.WIDTH(8)) u_buf (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .in_valid(f_valid),
    .in_ready(f_ready),
    .in_data(chr),
    .out_valid(u_valid),
    .out_ready(u_ready),
    .out_data(u_data)
  );

  rdoc_uart_tx #(.BIT_CYCLES(rdoc_pkg::BIT_CYC)) u_tx (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .chr_valid(u_valid),
    .chr_ready(u_ready),
    .chr_data(u_data),
    .tx_line(tx_line),
    .tx_busy(tx_busy)
  );

  // Registered pin drivers
  logic ser_ff;
  logic lb_out_ff;
  logic sleep_ff;
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ser_ff <= 1'b1;
      lb_out_ff <= 1'b1;
      sleep_ff <= 1'b0;
    end
    else
    begin
      ser_ff <= tx_line;
      lb_out_ff <= asleep ? 1'b1 : ~lb_ff; // [R11] [R22]
      sleep_ff <= asleep && lrn_state_ff == LS_IDLE; // [R21] [R23]
    end
  end

  // Slot count follows EEPROM presence, updated every cycle after reset [R17]
  logic [5:0] slots_ff;
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      slots_ff <= 6'(rdoc_pkg::INT_SLOTS);
    else
      slots_ff <= eeprom_present ? 6'(rdoc_pkg::EXT_SLOTS)
        : 6'(rdoc_pkg::INT_SLOTS); // [R17]
  end

  assign decoded_output_1 = out_ff[0];
  assign decoded_output_2 = out_ff[1];
  assign decoded_output_3 = out_ff[2];
  assign decoded_output_4 = out_ff[3];
  assign low_battery_flag = lb_out_ff;
  assign ascii_serial_out = ser_ff;
  // LED sinks the pin low; open-drain so the switch still reads [R19]
  assign learn_erase_pin_out = 1'b0;
  assign learn_erase_pin_oe = oe_ff;
  assign eeprom_select = sel_ff;
  assign eeprom_serial_clock_out = 1'b0;
  assign eeprom_serial_clock_oe = sel_ff; // [R12]
  assign learn_store_req = store_ff;
  assign erase_req = erase_ff;
  assign sync_high_fm = fm_ff; // [R13]
  assign slot_limit = slots_ff;
  assign sleeping = sleep_ff;
endmodule : rdoc_top

// *** testbench/rdoc_top_properties.sv ***
// Concurrent checks on the ports of the remote decoder output block.
// Assumes one sys_clk domain and a synchronous active-high sys_rst.
module rdoc_top_properties #(
  parameter int unsigned ERASE_CYCLES = rdoc_pkg::ERASE_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Watched inputs
  input wire logic pkt_valid,
  input wire logic pkt_coding_ok,
  input wire logic pkt_learnt,
  input wire logic pkt_low_batt,
  input wire logic eeprom_present,
  input wire logic learn_erase_pin_in,
  input wire logic eeprom_serial_clock_in,
  input wire logic sleep_run_n,
  // Watched outputs
  input wire logic decoded_output_1,
  input wire logic decoded_output_2,
  input wire logic decoded_output_3,
  input wire logic decoded_output_4,
  input wire logic low_battery_flag,
  input wire logic learn_erase_pin_out,
  input wire logic learn_erase_pin_oe,
  input wire logic eeprom_select,
  input wire logic eeprom_serial_clock_oe,
  input wire logic erase_req,
  input wire logic sync_high_fm,
  input wire logic [5:0] slot_limit,
  input wire logic sleeping
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [31:0] hold_ff;
  // Raw pin is ahead of the design's synchroniser, so it never undercounts
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || learn_erase_pin_in)
      hold_ff <= 32'h0;
    else if (hold_ff != 32'hFFFFFFFF)
      hold_ff <= hold_ff + 32'h1;
  end
  chk_sleep_outs_high: assert property (sleeping && $past(sleeping) |->
    {decoded_output_1, decoded_output_2, decoded_output_3,
     decoded_output_4, low_battery_flag} == 5'h1F)
    else $error("outputs not high while asleep");
  chk_clk_pin_input: assert property (!eeprom_select |->
    !eeprom_serial_clock_oe) else $error("clock pin driven while deselected");
  chk_strap_pull_up: assert property (
    (!eeprom_select && eeprom_serial_clock_in) [*5] |-> sync_high_fm)
    else $error("pull-up strap not taken as FM");
  chk_strap_pull_down: assert property (
    (!eeprom_select && !eeprom_serial_clock_in) [*5] |-> !sync_high_fm)
    else $error("pull-down strap not taken as AM");
  chk_ext_slot_count: assert property (eeprom_present [*3] |->
    slot_limit == 6'h30) else $error("slot limit not 48");
  chk_int_slot_count: assert property (!eeprom_present [*3] |->
    slot_limit == 6'h07) else $error("slot limit not 7");
  chk_led_sinks_low: assert property (learn_erase_pin_oe |->
    !learn_erase_pin_out) else $error("LED drive not low");
  chk_erase_needs_hold: assert property ($rose(erase_req) |->
    hold_ff >= ERASE_CYCLES) else $error("erase started on short press");
  chk_lowbatt_cause: assert property (
    $past(sleep_run_n, 3) && $past(sleep_run_n, 4) &&
    $fell(low_battery_flag) |->
    $past(pkt_valid && pkt_coding_ok && pkt_low_batt && pkt_learnt, 2) ||
    $past(pkt_valid && pkt_coding_ok && pkt_low_batt && pkt_learnt, 3))
    else $error("battery flag fell without a low-battery packet");
endmodule : rdoc_top_properties

// *** testbench/rdoc_host_model.sv ***
// Far side: host serial receiver and the data-mark strap resistor.
// Assumes the serial line idles high and the strap is a weak resistor.
module rdoc_host_model #(
  parameter int unsigned BIT_CYCLES = rdoc_pkg::BIT_CYC
) (
  // Clock
  input wire logic sys_clk,
  // Serial record line
  input wire logic serial_line,
  output logic [7:0] rx_byte,
  output int rx_count,
  output logic [7:0] frame_errs,
  // Strap on the shared EEPROM clock line
  input wire logic strap_up,
  input wire logic clk_pin_oe,
  input wire logic clk_pin_out,
  output logic clk_pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Resistor level shows only while the decoder lets go of the line
  assign clk_pin_level = clk_pin_oe ? clk_pin_out : strap_up;
  // Mid-bit sampling, LSB first, stop bit must be high
  initial
  begin
    rx_count = 0;
    frame_errs = 8'h00;
    rx_byte = 8'h00;
    forever
    begin
      @(negedge serial_line);
      repeat (BIT_CYCLES / 2) @(posedge sys_clk);
      if (serial_line === 1'b0)
      begin
        for (int i = 0; i < 8; i++)
        begin
          repeat (BIT_CYCLES) @(posedge sys_clk);
          rx_byte[i] = serial_line;
        end
        repeat (BIT_CYCLES) @(posedge sys_clk);
        if (serial_line !== 1'b1)
          frame_errs = frame_errs + 8'h01;
        rx_count = rx_count + 1;
      end
    end
  end
endmodule : rdoc_host_model

// *** testbench/rdoc_top_tb.sv ***
// Self-checking bench: packets, output modes, strap, learn, erase, sleep.
// Assumes the host model decodes the serial line and drives the strap.
module rdoc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned MOM = 50;
  localparam int unsigned ERASE = 500;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic pkt_valid = 1'b0, pkt_coding_ok = 1'b0, pkt_learnt = 1'b0;
  logic [27:0] pkt_serial = 28'h0;
  logic encoder_switch_0 = 1'b0, encoder_switch_1 = 1'b0;
  logic encoder_switch_2 = 1'b0, encoder_switch_3 = 1'b0;
  logic pkt_low_batt = 1'b0, rx_active = 1'b0, output_action_select = 1'b1;
  logic sleep_run_n = 1'b1, eeprom_present = 1'b0, erase_done = 1'b0;
  logic press = 1'b0, strap_up = 1'b1;
  logic decoded_output_1, decoded_output_2, decoded_output_3;
  logic decoded_output_4, low_battery_flag, ascii_serial_out;
  logic learn_erase_pin_in, learn_erase_pin_out, learn_erase_pin_oe;
  logic eeprom_select, eeprom_serial_clock_in, eeprom_serial_clock_out;
  logic eeprom_serial_clock_oe, learn_store_req, erase_req, sync_high_fm;
  logic [5:0] slot_limit;
  logic sleeping;
  logic [7:0] rx_byte, frame_errs;
  int rx_count;
  int err_count = 0, checks = 0, cyc = 0, stores = 0;
  wire logic [3:0] outs = {decoded_output_4, decoded_output_3,
    decoded_output_2, decoded_output_1};
  // Pull-up on the shared pin; the switch or the LED drive pulls it low
  assign learn_erase_pin_in = ~press &
    (learn_erase_pin_oe ? learn_erase_pin_out : 1'b1);

  rdoc_top #(.REC_GAP_CYCLES(2000), .MOM_CYCLES(MOM), .ERASE_CYCLES(ERASE),
    .FLASH_CYCLES(20)) DUT (.sys_clk, .sys_rst, .pkt_valid, .pkt_coding_ok,
    .pkt_learnt, .pkt_serial, .encoder_switch_0, .encoder_switch_1,
    .encoder_switch_2, .encoder_switch_3, .pkt_low_batt, .rx_active,
    .output_action_select, .sleep_run_n, .decoded_output_1,
    .decoded_output_2, .decoded_output_3, .decoded_output_4,
    .low_battery_flag, .ascii_serial_out, .learn_erase_pin_in,
    .learn_erase_pin_out, .learn_erase_pin_oe, .eeprom_present,
    .eeprom_select, .eeprom_serial_clock_in, .eeprom_serial_clock_out,
    .eeprom_serial_clock_oe, .learn_store_req, .erase_req, .erase_done,
    .sync_high_fm, .slot_limit, .sleeping);
  rdoc_host_model HOST (.sys_clk, .serial_line(ascii_serial_out), .rx_byte,
    .rx_count, .frame_errs, .strap_up, .clk_pin_oe(eeprom_serial_clock_oe),
    .clk_pin_out(eeprom_serial_clock_out),
    .clk_pin_level(eeprom_serial_clock_in));

  always #5 sys_clk = ~sys_clk;

  task automatic end_of_test;
    $display("checks %0d, errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // One character takes about 104k cycles; only the first character of the record is awaited
  always @(posedge sys_clk)
  begin
    cyc++;
    if (learn_store_req === 1'b1)
      stores++;
    if (cyc == 150000)
    begin
      err_count++;
      $display("unexpected at %0t: run did not finish", $time);
      end_of_test();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // LED drive is gapped for switch reads, so look over one 16-cycle scan
  task automatic led(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (16)
    begin
      @(posedge sys_clk);
      seen = seen | learn_erase_pin_oe;
    end
    chk(seen, exp);
  endtask : led

  task automatic chk(input logic [7:0] act, input logic [7:0] exp);
    checks++;
    if (act !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h, want %h", $time, act, exp);
    end
  endtask : chk

  // Fields go to their inverse once the strobe is gone
  task automatic pkt(input logic [27:0] sn, input logic [3:0] sw,
    input logic lb, input logic known);
    pkt_valid <= 1'b1;
    pkt_coding_ok <= 1'b1;
    pkt_learnt <= known;
    pkt_serial <= sn;
    {encoder_switch_3, encoder_switch_2, encoder_switch_1,
     encoder_switch_0} <= sw;
    pkt_low_batt <= lb;
    @(posedge sys_clk);
    pkt_valid <= 1'b0;
    pkt_coding_ok <= 1'b0;
    pkt_learnt <= ~known;
    pkt_serial <= ~sn;
    {encoder_switch_3, encoder_switch_2, encoder_switch_1,
     encoder_switch_0} <= ~sw;
    pkt_low_batt <= ~lb;
    tick(5);
  endtask : pkt

  initial
  begin
    tick(2);
    sys_rst <= 1'b0;
    tick(6);
    chk({low_battery_flag, outs}, 8'h1F);
    chk(ascii_serial_out, 8'h01);
    chk(sync_high_fm, 8'h01);
    chk(slot_limit, 8'h07);
    eeprom_present <= 1'b1;
    strap_up <= 1'b0;
    tick(6);
    chk(slot_limit, 8'h30);
    chk(sync_high_fm, 8'h00);
    chk(eeprom_serial_clock_oe, 8'h00);
    eeprom_present <= 1'b0;
    pkt(28'hA345678, 4'h1, 1'b0, 1'b1);
    chk(outs, 8'h0E);
    pkt(28'h1234567, 4'h1, 1'b0, 1'b0);
    chk(outs, 8'h0E);
    pkt(28'hA345678, 4'h1, 1'b0, 1'b1);
    chk(outs, 8'h0F);
    pkt(28'hA345678, 4'h0, 1'b1, 1'b1);
    chk(low_battery_flag, 8'h00);
    pkt(28'hA345678, 4'h0, 1'b0, 1'b1);
    chk(low_battery_flag, 8'h01);
    output_action_select <= 1'b0;
    rx_active <= 1'b1;
    pkt(28'hA345678, 4'h2, 1'b0, 1'b1);
    chk(outs, 8'h0D);
    rx_active <= 1'b0;
    tick(MOM / 2);
    chk(outs, 8'h0D);
    tick(MOM);
    chk(outs, 8'h0F);
    press <= 1'b1;
    tick(24);
    led(1'b1);
    press <= 1'b0;
    tick(24);
    led(1'b1);
    pkt(28'h0BCDEF1, 4'h1, 1'b0, 1'b0);
    led(1'b0);
    pkt(28'h0BCDEF1, 4'h1, 1'b0, 1'b0);
    chk(stores, 8'h01);
    tick(150);
    led(1'b0);
    chk(erase_req, 8'h00);
    press <= 1'b1;
    tick(ERASE + 40);
    chk(erase_req, 8'h01);
    led(1'b1);
    press <= 1'b0;
    tick(30);
    erase_done <= 1'b1;
    tick(5);
    chk(erase_req, 8'h00);
    erase_done <= 1'b0;
    tick(5);
    led(1'b0);
    output_action_select <= 1'b1;
    pkt(28'hA345678, 4'h4, 1'b1, 1'b1);
    chk({low_battery_flag, outs}, 8'h0B);
    sleep_run_n <= 1'b0;
    tick(6);
    chk(sleeping, 8'h01);
    chk({low_battery_flag, outs}, 8'h1F);
    press <= 1'b1;
    tick(24);
    led(1'b1);
    press <= 1'b0;
    sleep_run_n <= 1'b1;
    tick(6);
    chk(sleeping, 8'h00);
    for (int i = 0; i < 120000 && rx_count == 0; i++)
      @(posedge sys_clk);
    chk(rx_byte, 8'h41);
    chk(frame_errs, 8'h00);
    end_of_test();
  end
endmodule : rdoc_top_tb

bind rdoc_top rdoc_top_properties #(.ERASE_CYCLES(ERASE_CYCLES)) u_props (
  .sys_clk, .sys_rst, .pkt_valid, .pkt_coding_ok, .pkt_learnt, .pkt_low_batt,
  .eeprom_present, .learn_erase_pin_in, .eeprom_serial_clock_in,
  .decoded_output_1, .decoded_output_2, .decoded_output_3, .decoded_output_4,
  .low_battery_flag, .learn_erase_pin_out, .learn_erase_pin_oe,
  .eeprom_select, .eeprom_serial_clock_oe, .erase_req, .sync_high_fm,
  .slot_limit, .sleeping, .sleep_run_n);
